// >>> design/abort_flag_if.sv
// Connection between the header bank and one sticky abort flag
`timescale 1ns/1ps
interface abort_flag_if;
   logic set;
   logic clr;
   logic q;
   modport owner (input set, input clr, output q);
   modport user (output set, output clr, input q);
endinterface : abort_flag_if

// >>> design/host_bridge_cfg_pkg.sv
// Constants of the host bridge configuration header
package host_bridge_cfg_pkg;
   // -------------------------------------------------------
   // Host I/O ports of the configuration mechanism
   // -------------------------------------------------------
   localparam logic [15:0] IO_CONF_ADDR = 16'h0CF8;
   localparam logic [15:0] IO_CONF_DATA = 16'h0CFC;
   localparam logic [31:0] CONF_ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] CONF_ADDR_MASK = 32'h80FF_FFFC;
   localparam int CONF_EN_BIT = 31;
   localparam int CONF_BUS_LSB = 16;
   localparam int CONF_DEV_LSB = 11;
   localparam int CONF_FUNC_LSB = 8;
   localparam int CONF_REG_LSB = 2;
   // -------------------------------------------------------
   // Configuration space byte offsets
   // -------------------------------------------------------
   localparam logic [7:0] OFF_VENDOR_LO = 8'h00;
   localparam logic [7:0] OFF_VENDOR_HI = 8'h01;
   localparam logic [7:0] OFF_DEVICE_LO = 8'h02;
   localparam logic [7:0] OFF_DEVICE_HI = 8'h03;
   localparam logic [7:0] OFF_COMMAND_LO = 8'h04;
   localparam logic [7:0] OFF_COMMAND_HI = 8'h05;
   localparam logic [7:0] OFF_STATUS_LO = 8'h06;
   localparam logic [7:0] OFF_STATUS_HI = 8'h07;
   localparam logic [7:0] OFF_REVISION = 8'h08;
   localparam logic [7:0] OFF_SUB_CLASS = 8'h0A;
   localparam logic [7:0] OFF_BASE_CLASS = 8'h0B;
   localparam logic [7:0] OFF_BURST_TIMER = 8'h0D;
   localparam logic [7:0] OFF_SELF_TEST = 8'h0F;
   localparam logic [7:0] OFF_BUS_UNIT_CTRL = 8'h50;
   localparam logic [7:0] OFF_CACHE_CTRL = 8'h52;
   localparam logic [7:0] OFF_MEM_CTRL = 8'h57;
   localparam logic [7:0] OFF_MEM_TIMING = 8'h58;
   localparam logic [7:0] OFF_ATTR_MAP_FIRST = 8'h59;
   localparam logic [7:0] OFF_ATTR_MAP_LAST = 8'h5F;
   localparam logic [7:0] OFF_ROW_BOUND_FIRST = 8'h60;
   localparam logic [7:0] OFF_ROW_BOUND_LAST = 8'h64;
   localparam logic [7:0] OFF_ROW_TYPE = 8'h68;
   localparam logic [7:0] OFF_SMM_CTRL = 8'h72;
   // -------------------------------------------------------
   // Field positions, fixed codes and reset values
   // -------------------------------------------------------
   localparam int CMD_MEM_EN_BIT = 1;
   localparam int STS_HI_MASTER_ABORT_BIT = 5;
   localparam int STS_HI_TARGET_ABORT_BIT = 4;
   localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
   localparam logic [15:0] COMMAND_RESET = 16'h0006;
   localparam logic [15:0] STATUS_RESET = 16'h0200;
   localparam logic [7:0] SUB_CLASS_VAL = 8'h00;
   localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
   localparam logic [7:0] BURST_TIMER_MASK = 8'hF8;
   localparam logic [7:0] CTRL_BYTE_RESET = 8'h00;
endpackage : host_bridge_cfg_pkg

// >>> design/host_bridge_pci_config_header.sv
// Configuration header register bank of the host-to-PCI bridge
`timescale 1ns/1ps
// Operation
// - Vendor identity read-only at 00h-01h
// - Device identity read-only at 02h-03h
// - Unimplemented command bits always read zero
// - Bus master enable always reads one
// - Memory enable gates PCI memory claims
// - I/O enable zero, no I/O claims
// - Command reads 06h after reset
// - Unexpected master abort sets bit 13
// - Special cycle master abort sets nothing
// - Target abort sets bit 12, write-one clears
// - Bit 11 zero, no target aborts
// - Select timing field reads medium code
// - Parity, system error, fast flags read zero
// - Status reads 0200h after reset
// - Decode map: controls at 0Dh and at selected bytes from 50h to 72h
// - Local only as bus0 dev0 func0
module host_bridge_pci_config_header #(
   parameter logic [15:0] VENDOR_ID_VAL = 16'h1A2B, // arbitrary value
   parameter logic [15:0] DEVICE_ID_VAL = 16'h3C4D, // arbitrary value
   parameter logic [7:0] REVISION_VAL = 8'h01 // arbitrary value
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic io_req,
   input wire logic io_write,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic [31:0] io_wdata,
   output logic io_ack,
   output logic [31:0] io_rdata,
   input wire logic pci_master_abort,
   input wire logic pci_special_cycle,
   input wire logic pci_target_abort,
   input wire logic pci_mem_hit,
   output logic pci_mem_claim,
   output logic pci_io_claim,
   output logic cfg_fwd,
   output logic cfg_fwd_no_select,
   output logic [31:0] cfg_fwd_addr
);
   // -------------------------------------------------------
   // State
   // -------------------------------------------------------
   logic [31:0] conf_addr_ff;
   logic mem_en_ff;
   logic [7:0] ctrl_ff [0:255];
   logic io_ack_ff;
   logic [31:0] io_rdata_ff;
   logic cfg_fwd_ff;
   logic cfg_fwd_no_select_ff;
   logic [31:0] cfg_fwd_addr_ff;
   logic take;
   logic hit_addr;
   logic hit_data;
   logic addr_wr;
   logic data_acc;
   logic local_tgt;
   logic no_select;
   logic local_acc;
   logic local_wr;
   logic local_rd;
   logic [5:0] reg_idx;
   logic [15:0] cmd_val;
   logic [15:0] sts_val;
   logic received_master_abort_flag_q;
   logic received_target_abort_flag_q;

   abort_flag_if master_abort_flag ();
   abort_flag_if target_abort_flag ();

   // -------------------------------------------------------
   // Helper functions for the configuration map
   // -------------------------------------------------------

   // Byte offsets that hold a plain read/write control byte
   function automatic logic is_ctrl(input logic [7:0] off);
      logic hit;
      hit = 1'b0;
      if (off == host_bridge_cfg_pkg::OFF_BURST_TIMER) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_BUS_UNIT_CTRL) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_CACHE_CTRL) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_MEM_CTRL) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_MEM_TIMING) begin
         hit = 1'b1;
      end
      if (off >= host_bridge_cfg_pkg::OFF_ATTR_MAP_FIRST &&
          off <= host_bridge_cfg_pkg::OFF_ATTR_MAP_LAST) begin
         hit = 1'b1;
      end
      if (off >= host_bridge_cfg_pkg::OFF_ROW_BOUND_FIRST &&
          off <= host_bridge_cfg_pkg::OFF_ROW_BOUND_LAST) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_ROW_TYPE) begin
         hit = 1'b1;
      end
      if (off == host_bridge_cfg_pkg::OFF_SMM_CTRL) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_ctrl

   // Bits of a control byte that software can change
   function automatic logic [7:0] ctrl_mask(input logic [7:0] off);
      logic [7:0] m;
      m = 8'hFF;
      if (off == host_bridge_cfg_pkg::OFF_BURST_TIMER) begin
         m = host_bridge_cfg_pkg::BURST_TIMER_MASK;
      end
      return m;
   endfunction : ctrl_mask

   // -------------------------------------------------------
   // Host access decode
   // -------------------------------------------------------

   // One request at a time; the ack cycle takes nothing new
   assign take = ce && io_req && !io_ack_ff;
   assign hit_addr = io_addr == host_bridge_cfg_pkg::IO_CONF_ADDR;
   assign hit_data = io_addr == host_bridge_cfg_pkg::IO_CONF_DATA;
   // Only whole doublewords reach the address register
   assign addr_wr = take && io_write && hit_addr && (io_be == 4'hF);
   assign data_acc = take && hit_data &&
      conf_addr_ff[host_bridge_cfg_pkg::CONF_EN_BIT];

   // Bus 0, device 0: our own configuration space
   assign local_tgt = (conf_addr_ff[23:16] == 8'h00) &&
      (conf_addr_ff[15:11] == 5'h00);
   assign no_select = local_tgt && (conf_addr_ff[10:8] != 3'h0);
   assign local_acc = data_acc && local_tgt && !no_select;
   assign local_wr = local_acc && io_write;
   assign local_rd = local_acc && !io_write;
   assign reg_idx = conf_addr_ff[7:2];

   // -------------------------------------------------------
   // Composed header words
   // -------------------------------------------------------

   // Command: fixed master enable, only memory enable stored
   assign cmd_val = {13'h0000, 1'b1, mem_en_ff, 1'b0};
   // Status: abort flags plus fixed medium select timing
   assign sts_val = {2'b00, received_master_abort_flag_q, received_target_abort_flag_q, 1'b0,
      host_bridge_cfg_pkg::SELECT_TIMING_MEDIUM, 9'h000};

   // Read value of one configuration byte
   function automatic logic [7:0] rd_byte(input logic [7:0] off);
      logic [7:0] v;
      v = 8'h00;
      unique case (off)
         host_bridge_cfg_pkg::OFF_VENDOR_LO: v = VENDOR_ID_VAL[7:0];
         host_bridge_cfg_pkg::OFF_VENDOR_HI: v = VENDOR_ID_VAL[15:8];
         host_bridge_cfg_pkg::OFF_DEVICE_LO: v = DEVICE_ID_VAL[7:0];
         host_bridge_cfg_pkg::OFF_DEVICE_HI: v = DEVICE_ID_VAL[15:8];
         host_bridge_cfg_pkg::OFF_COMMAND_LO: v = cmd_val[7:0];
         host_bridge_cfg_pkg::OFF_COMMAND_HI: v = cmd_val[15:8];
         host_bridge_cfg_pkg::OFF_STATUS_LO: v = sts_val[7:0];
         host_bridge_cfg_pkg::OFF_STATUS_HI: v = sts_val[15:8];
         host_bridge_cfg_pkg::OFF_REVISION: v = REVISION_VAL;
         host_bridge_cfg_pkg::OFF_SUB_CLASS: v = host_bridge_cfg_pkg::SUB_CLASS_VAL;
         host_bridge_cfg_pkg::OFF_BASE_CLASS: v = host_bridge_cfg_pkg::BASE_CLASS_VAL;
         default: begin
            if (is_ctrl(off)) begin
               v = ctrl_ff[off] & ctrl_mask(off);
            end
         end
      endcase
      return v;
   endfunction : rd_byte

   // -------------------------------------------------------
   // Configuration address register
   // -------------------------------------------------------

   // Reserved bits are never stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conf_addr_ff <= host_bridge_cfg_pkg::CONF_ADDR_RESET;
      end else if (addr_wr) begin
         conf_addr_ff <= io_wdata & host_bridge_cfg_pkg::CONF_ADDR_MASK;
      end
   end

   // -------------------------------------------------------
   // Command register
   // -------------------------------------------------------

   // Memory enable is the only stored command bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_en_ff <= host_bridge_cfg_pkg::COMMAND_RESET[1];
      end else if (local_wr && reg_idx == 6'h01 && io_be[0]) begin
         mem_en_ff <= io_wdata[host_bridge_cfg_pkg::CMD_MEM_EN_BIT];
      end
   end

   // Memory claims only while memory enable is set; never I/O
   assign pci_mem_claim = pci_mem_hit && mem_en_ff;
   assign pci_io_claim = 1'b0;

   // -------------------------------------------------------
   // Abort status flags
   // -------------------------------------------------------

   // Special cycles end in master abort by design
   assign master_abort_flag.set = ce && pci_master_abort && !pci_special_cycle;
   assign master_abort_flag.clr = local_wr && reg_idx == 6'h01 && io_be[3] &&
      io_wdata[24 + host_bridge_cfg_pkg::STS_HI_MASTER_ABORT_BIT];
   assign target_abort_flag.set = ce && pci_target_abort;
   assign target_abort_flag.clr = local_wr && reg_idx == 6'h01 && io_be[3] &&
      io_wdata[24 + host_bridge_cfg_pkg::STS_HI_TARGET_ABORT_BIT];
   assign received_master_abort_flag_q = master_abort_flag.q;
   assign received_target_abort_flag_q = target_abort_flag.q;

   sticky_flag u_master_abort (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .f(master_abort_flag)
   );

   sticky_flag u_target_abort (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .f(target_abort_flag)
   );

   // -------------------------------------------------------
   // Control byte storage
   // -------------------------------------------------------

   // Lanes write only bytes mapped as control registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 256; i++) begin
            ctrl_ff[i] <= host_bridge_cfg_pkg::CTRL_BYTE_RESET;
         end
      end else if (local_wr) begin
         for (int l = 0; l < 4; l++) begin
            if (io_be[l] && is_ctrl({reg_idx, 2'(l)})) begin
               ctrl_ff[{reg_idx, 2'(l)}] <= io_wdata[8*l +: 8];
            end
         end
      end
   end

   // -------------------------------------------------------
   // Host answer
   // -------------------------------------------------------

   // Ack one cycle after a request is taken
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_ack_ff <= 1'b0;
      end else if (ce) begin
         io_ack_ff <= take;
      end
   end

   // Read data for the address register and local space
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata_ff <= 32'h0000_0000;
      end else if (take) begin
         io_rdata_ff <= 32'h0000_0000;
         if (hit_addr && io_be == 4'hF) begin
            io_rdata_ff <= conf_addr_ff;
         end else if (local_rd) begin
            for (int l = 0; l < 4; l++) begin
               io_rdata_ff[8*l +: 8] <= rd_byte({reg_idx, 2'(l)});
            end
         end
      end
   end

   assign io_ack = io_ack_ff;
   assign io_rdata = io_rdata_ff;

   // -------------------------------------------------------
   // Forwarding of other configuration accesses to PCI
   // -------------------------------------------------------

   // One-cycle pulse with the address phase value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_fwd_ff <= 1'b0;
         cfg_fwd_no_select_ff <= 1'b0;
         cfg_fwd_addr_ff <= 32'h0000_0000;
      end else if (ce) begin
         cfg_fwd_ff <= data_acc && !local_acc;
         if (data_acc && !local_acc) begin
            cfg_fwd_no_select_ff <= no_select;
            cfg_fwd_addr_ff <= conf_addr_ff;
         end
      end
   end

   assign cfg_fwd = cfg_fwd_ff;
   assign cfg_fwd_no_select = cfg_fwd_no_select_ff;
   assign cfg_fwd_addr = cfg_fwd_addr_ff;

   // -------------------------------------------------------
   // Checks
   // -------------------------------------------------------

   a_ident_read: assert property (
      @(posedge clk) disable iff (!reset_n)
      (local_rd && reg_idx == 6'h00) |=> io_rdata == {DEVICE_ID_VAL, VENDOR_ID_VAL})
      else $error("identity read wrong");
   a_cmd_fixed_bits: assert property (
      @(posedge clk) disable iff (!reset_n)
      (local_rd && reg_idx == 6'h01) |=> io_rdata[15:3] == 13'h0000 && !io_rdata[0])
      else $error("command fixed bits not zero");
   a_master_en_one: assert property (
      @(posedge clk) disable iff (!reset_n)
      (local_rd && reg_idx == 6'h01) |=> io_rdata[2])
      else $error("bus master enable not one");
   a_mem_claim_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      pci_mem_claim |-> (pci_mem_hit && mem_en_ff))
      else $error("memory claimed while disabled");
   a_no_io_claim: assert property (
      @(posedge clk) disable iff (!reset_n)
      !pci_io_claim)
      else $error("I/O cycle claimed");
   a_master_abort_set: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ce && pci_master_abort && !pci_special_cycle) |=> received_master_abort_flag_q)
      else $error("master abort not recorded");
   a_special_no_set: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!received_master_abort_flag_q && ce && pci_master_abort && pci_special_cycle) |=> !received_master_abort_flag_q)
      else $error("special cycle set master abort");
   a_target_abort_set: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ce && pci_target_abort) |=> received_target_abort_flag_q)
      else $error("target abort not recorded");
   a_status_fixed: assert property (
      @(posedge clk) disable iff (!reset_n)
      (local_rd && reg_idx == 6'h01) |=> io_rdata[26:25] == 2'h1 &&
         io_rdata[31:30] == 2'h0 && io_rdata[27] == 1'b0 && io_rdata[24:16] == 9'h000)
      else $error("status fixed bits wrong");
   a_reserved_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      (local_rd && reg_idx >= 6'h04 && reg_idx <= 6'h13) |=> io_rdata == 32'h0000_0000)
      else $error("reserved offset not zero");
   a_no_select_fwd: assert property (
      @(posedge clk) disable iff (!reset_n)
      (data_acc && no_select) |=> cfg_fwd && cfg_fwd_no_select)
      else $error("other function not forwarded");
   a_ack_follows: assert property (
      @(posedge clk) disable iff (!reset_n)
      take |=> io_ack ##1 !io_ack)
      else $error("ack not one cycle");

   c_local_write: cover property (
      @(posedge clk) disable iff (!reset_n) local_wr && reg_idx == 6'h14);
   c_abort_clear: cover property (
      @(posedge clk) disable iff (!reset_n) received_master_abort_flag_q ##1 !received_master_abort_flag_q);
   c_forward: cover property (
      @(posedge clk) disable iff (!reset_n) cfg_fwd && !cfg_fwd_no_select);
endmodule : host_bridge_pci_config_header

// >>> design/sticky_flag.sv
// Sticky status flag, set by hardware, cleared by software
`timescale 1ns/1ps
module sticky_flag (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   abort_flag_if.owner f
);
   logic flag_ff;

   // Set has priority over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_ff <= 1'b0;
      end else if (ce) begin
         if (f.set) begin
            flag_ff <= 1'b1;
         end else if (f.clr) begin
            flag_ff <= 1'b0;
         end
      end
   end

   assign f.q = flag_ff;

   a_set_beats_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ce && f.set && f.clr) |=> f.q)
      else $error("flag lost on simultaneous set and clear");
   a_clear_takes: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ce && !f.set && f.clr) |=> !f.q)
      else $error("flag not cleared");
endmodule : sticky_flag

// >>> tb/host_bridge_pci_config_header_tb.sv
// Self-checking bench of the configuration header bank
`timescale 1ns/1ps
module host_bridge_pci_config_header_tb;
   localparam logic [15:0] VEN = 16'h5A17; // arbitrary value
   localparam logic [15:0] DEV = 16'h6B29; // arbitrary value
   localparam int NMAP = 10;
   localparam int NFWD = 4;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic io_req = 1'b0;
   logic io_write = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [3:0] io_be = 4'h0;
   logic [31:0] io_wdata = 32'h0000_0000;
   logic io_ack, pci_mem_claim, pci_io_claim, cfg_fwd, cfg_fwd_no_select;
   logic [31:0] io_rdata, cfg_fwd_addr, rd, fwd_addr;
   logic ma, sc, ta, hit, fwd, nosel;
   int err_total = 0;
   int check_count = 0;
   logic [7:0] map_off [NMAP] = '{8'h08, 8'h0C, 8'h40, 8'h50, 8'h54, 8'h5C, 8'h64, 8'h68,
      8'h70, 8'h74};
   logic [31:0] map_wr [NMAP] = '{32'h0600_0003, 32'h0000_F800, 32'h0, 32'h00FF_00FF,
      32'hFF00_0000, 32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_00FF, 32'h00FF_0000, 32'h0};
   logic [31:0] fwd_a [NFWD] = '{32'h8000_0100, 32'h8000_0800, 32'h8001_0000, 32'h0000_0004};
   logic [1:0] fwd_e [NFWD] = '{2'h3, 2'h2, 2'h2, 2'h0};

   // Clock and instances
   always #2 clk = ~clk;
   host_bridge_pci_config_header #(.VENDOR_ID_VAL(VEN), .DEVICE_ID_VAL(DEV),
      .REVISION_VAL(8'h03)) i_host_bridge_pci_config_header (
      .clk(clk), .reset_n(reset_n), .ce(ce), .io_req(io_req), .io_write(io_write),
      .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack),
      .io_rdata(io_rdata), .pci_master_abort(ma), .pci_special_cycle(sc),
      .pci_target_abort(ta), .pci_mem_hit(hit), .pci_mem_claim(pci_mem_claim),
      .pci_io_claim(pci_io_claim), .cfg_fwd(cfg_fwd), .cfg_fwd_no_select(cfg_fwd_no_select),
      .cfg_fwd_addr(cfg_fwd_addr));
   pci_event_model i_pci_event_model (.clk(clk), .master_abort(ma), .special_cycle(sc),
      .target_abort(ta), .mem_hit(hit));

   // -------------------------------------------------------
   // Access and compare tasks
   // -------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One host I/O cycle, held until acknowledged
   task automatic access(input logic wr, input logic [15:0] a, input logic [3:0] be,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      io_req <= 1'b1;
      io_write <= wr;
      io_addr <= a;
      io_be <= be;
      io_wdata <= d;
      @(posedge clk);
      while (io_ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         err_total++;
         $display("unexpected io_ack: expected 1 seen timeout");
         results();
      end
      rd = io_rdata;
      fwd = cfg_fwd;
      nosel = cfg_fwd_no_select;
      fwd_addr = cfg_fwd_addr;
      io_req <= 1'b0;
   endtask : access

   task automatic sel(input logic [31:0] a);
      access(1'b1, 16'h0CF8, 4'hF, a);
   endtask : sel

   task automatic wrd(input logic [3:0] be, input logic [31:0] d);
      access(1'b1, 16'h0CFC, be, d);
   endtask : wrd

   task automatic rchk(input string what, input logic [31:0] exp);
      access(1'b0, 16'h0CFC, 4'hF, 32'h0);
      chk(what, exp, rd);
   endtask : rchk

   // -------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      sel(32'h8000_0000);
      rchk("ids", {DEV, VEN});
      wrd(4'hF, 32'hFFFF_FFFF);
      rchk("ids kept", {DEV, VEN});
      sel(32'h8000_0004);
      rchk("cmd sts reset", 32'h0200_0006);
      i_pci_event_model.set_hit(1'b1);
      wrd(4'hF, 32'h0);
      rchk("cmd off", 32'h0200_0004);
      chk("mem claim off", 32'h0, {31'h0, pci_mem_claim});
      wrd(4'h3, 32'h0000_FFFF);
      rchk("cmd on", 32'h0200_0006);
      chk("mem claim on", 32'h1, {31'h0, pci_mem_claim});
      chk("io claim", 32'h0, {31'h0, pci_io_claim});
      $display("test command done");
      i_pci_event_model.pulse(1'b1, 1'b1, 1'b0);
      rchk("special abort", 32'h0200_0006);
      i_pci_event_model.pulse(1'b1, 1'b0, 1'b0);
      rchk("master abort", 32'h2200_0006);
      i_pci_event_model.pulse(1'b0, 1'b0, 1'b1);
      rchk("target abort", 32'h3200_0006);
      wrd(4'hC, 32'h0);
      rchk("zero write", 32'h3200_0006);
      fork
         wrd(4'h8, 32'h1000_0000);
         i_pci_event_model.pulse(1'b0, 1'b0, 1'b1);
      join
      rchk("set beats clear", 32'h3200_0006);
      wrd(4'hC, 32'hFFFF_0000);
      rchk("fixed status", 32'h0200_0006);
      // Abort seen while the clock enable is low must not be recorded
      @(posedge clk);
      ce <= 1'b0;
      i_pci_event_model.pulse(1'b0, 1'b0, 1'b1);
      ce <= 1'b1;
      rchk("frozen abort", 32'h0200_0006);
      $display("test status done");
      for (int i = 0; i < NMAP; i++) begin
         sel({24'h80_0000, map_off[i]});
         rchk("map reset", (i == 0) ? map_wr[0] : 32'h0);
         wrd(4'hF, 32'hFFFF_FFFF);
         rchk("map write", map_wr[i]);
      end
      $display("test map done");
      for (int i = 0; i < NFWD; i++) begin
         sel(fwd_a[i]);
         rchk("fwd read", 32'h0);
         chk("fwd flags", {30'h0, fwd_e[i]}, {30'h0, fwd, nosel});
         if (fwd_e[i] != 2'h0) begin
            chk("fwd addr", fwd_a[i], fwd_addr);
         end
      end
      // Partial accesses to the address register are refused
      access(1'b1, 16'h0CF8, 4'h1, 32'hFFFF_FFFF);
      access(1'b0, 16'h0CF8, 4'h3, 32'h0);
      chk("addr part read", 32'h0, rd);
      access(1'b0, 16'h0CF8, 4'hF, 32'h0);
      chk("addr readback", 32'h0000_0004, rd);
      access(1'b0, 16'h0080, 4'hF, 32'h0);
      chk("unmapped io", 32'h0, rd);
      $display("test forward done");
      results();
   end
endmodule : host_bridge_pci_config_header_tb

// >>> tb/pci_event_model.sv
// PCI side model: transaction terminations and memory hits
`timescale 1ns/1ps
module pci_event_model (
   input wire logic clk,
   output logic master_abort,
   output logic special_cycle,
   output logic target_abort,
   output logic mem_hit
);
   // Idle bus: no terminations, no hits
   initial begin
      master_abort = 1'b0;
      special_cycle = 1'b0;
      target_abort = 1'b0;
      mem_hit = 1'b0;
   end

   // -------------------------------------------------------
   // Stimulus tasks
   // -------------------------------------------------------
   // One-cycle termination of a bridge-initiated transaction
   task automatic pulse(input logic ma, input logic sc, input logic ta);
      @(posedge clk);
      master_abort <= ma;
      special_cycle <= sc;
      target_abort <= ta;
      @(posedge clk);
      master_abort <= 1'b0;
      special_cycle <= 1'b0;
      target_abort <= 1'b0;
   endtask : pulse

   // Master access hitting memory, whether memory enable is set or not
   task automatic set_hit(input logic h);
      @(posedge clk);
      mem_hit <= h;
   endtask : set_hit
endmodule : pci_event_model
